// ---- shared/amx_pkg.sv ----
// constants for the monitor mux, regulator and sink one config bank
// assumes an i2c target in front and analog/regulator/sink blocks behind
`default_nettype none
package amx_pkg;
  // --------------------
  // register offsets
  // --------------------
  localparam logic [7:0] REG_MON_MUX = 8'h28;
  localparam logic [7:0] REG_LDO_VOLT = 8'h30;
  localparam logic [7:0] REG_LDO_MODE = 8'h31;
  localparam logic [7:0] REG_SINK_ONE = 8'h40;
  // --------------------
  // field positions
  // --------------------
  localparam int MON_SEL_LSB = 0;
  localparam int MON_SEL_MSB = 3;
  localparam int MON_SCALE_LSB = 4;
  localparam int MON_SCALE_MSB = 7;
  localparam int LDO_ADE_BIT = 7;
  localparam int REGULATOR_VOLTAGE_CODE_MSB = 6;
  localparam int REGULATOR_POWER_MODE_LSB = 2;
  localparam int REGULATOR_POWER_MODE_MSB = 3;
  localparam int REGULATOR_ENABLE_MODE_MSB = 1;
  localparam int SINK_RANGE_LSB = 6;
  localparam int SINK_RANGE_MSB = 7;
  localparam int SINK_INV_BIT = 5;
  localparam int SINK_BRT_MSB = 4;
  // --------------------
  // reset values
  // --------------------
  localparam logic [7:0] MON_MUX_RST = 8'hF0;
  localparam logic LDO_ADE_RST = 1'h1;
  localparam logic [1:0] REGULATOR_POWER_MODE_RST = 2'h1;
  localparam logic [7:0] SINK_ONE_RST = 8'h04;
  // --------------------
  // field codes
  // --------------------
  localparam logic [3:0] MON_SEL_OFF = 4'h0;
  localparam logic [3:0] MON_SEL_BAT_CHARGE_I = 4'h4;
  localparam logic [1:0] PM_FORCED_LOW = 2'h0;
  localparam logic [1:0] PM_FORCED_NORMAL = 2'h1;
  localparam logic [1:0] PM_PIN_HIGH = 2'h2;
  localparam logic [1:0] PM_PIN_LOW = 2'h3;
  localparam logic [1:0] EN_FORCED_OFF = 2'h0;
  localparam logic [1:0] EN_FORCED_ON = 2'h1;
  localparam logic [1:0] SINK_RANGE_OFF = 2'h0;
  localparam logic [11:0] LDO_BASE_MV = 12'h320;
  localparam logic [11:0] LDO_STEP_MV = 12'h019;
  localparam logic [15:0] SINK_LSB_UA = 16'h0064;
  // --------------------
  // serial link
  // --------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // --------------------
  // analog monitor sources
  // --------------------
  typedef enum logic [3:0] {
    SRC_OFF,
    SRC_CHARGER_V,
    SRC_CHARGER_I,
    SRC_BATTERY_V,
    SRC_BATTERY_CHARGE_I,
    SRC_BATTERY_DISCHARGE_I,
    SRC_BATTERY_DISCHARGE_NULL,
    SRC_THERMISTOR_V,
    SRC_THERMISTOR_BIAS_V,
    SRC_ANALOG_GROUND,
    SRC_SYSTEM_RAIL
  } amx_src_t;
endpackage
`default_nettype wire

// ---- design/amx_i2c_line.sv ----
// edge and start/stop detection on the serial clock and data pins
// assumes pins already synchronous to clk and slow against it
`timescale 1ns/1ps
`default_nettype none
module amx_i2c_line (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  logic sclPrev_ff;
  logic sdaPrev_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclPrev_ff <= 1'h1;
      sdaPrev_ff <= 1'h1;
      sclRise <= 1'h0;
      sclFall <= 1'h0;
      startSeen <= 1'h0;
      stopSeen <= 1'h0;
    end else if (ce) begin
      sclPrev_ff <= scl;
      sdaPrev_ff <= sdaIn;
      sclRise <= !sclPrev_ff && scl;
      sclFall <= sclPrev_ff && !scl;
      // data moving while clock stays high marks frame edges
      startSeen <= sclPrev_ff && scl && sdaPrev_ff && !sdaIn;
      stopSeen <= sclPrev_ff && scl && !sdaPrev_ff && sdaIn;
    end
  end
endmodule
`default_nettype wire

// ---- design/amx_ctl_decode.sv ----
// turns stored fields and pins into registered control levels
// assumes field values are stable register outputs
`timescale 1ns/1ps
`default_nettype none
module amx_ctl_decode (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] monCfg,
  input wire logic [7:0] ldoVoltCfg,
  input wire logic [3:0] ldoModeCfg,
  input wire logic [7:0] sinkCfg,
  input wire logic powerModePin,
  input wire logic activeLowEnableIn_b,
  input wire logic chargerInputValid,
  input wire logic chargingIndication,
  input wire logic blinkDutyActive,
  output logic [3:0] monitorChannelSelect,
  output amx_pkg::amx_src_t monitorSource,
  output logic monitorBufferOn,
  output logic chargeMonitorValid,
  output logic [3:0] dischargeMonitorFullScale,
  output logic regulatorOn,
  output logic regulatorNormalMode,
  output logic regulatorActiveDischarge,
  output logic [6:0] regulatorVoltageCode,
  output logic [11:0] regulatorTargetMv,
  output logic sinkOneEnabled,
  output logic [1:0] sinkOneRange,
  output logic [15:0] sinkOneCurrentUa,
  output logic sinkOneOn
);
  function automatic amx_pkg::amx_src_t srcOf(input logic [3:0] sel);
    case (sel)
      4'h0: srcOf = amx_pkg::SRC_OFF;
      4'h1: srcOf = amx_pkg::SRC_CHARGER_V;
      4'h2: srcOf = amx_pkg::SRC_CHARGER_I;
      4'h3: srcOf = amx_pkg::SRC_BATTERY_V;
      4'h4: srcOf = amx_pkg::SRC_BATTERY_CHARGE_I;
      4'h5: srcOf = amx_pkg::SRC_BATTERY_DISCHARGE_I;
      4'h6: srcOf = amx_pkg::SRC_BATTERY_DISCHARGE_NULL;
      4'h7: srcOf = amx_pkg::SRC_THERMISTOR_V;
      4'h8: srcOf = amx_pkg::SRC_THERMISTOR_BIAS_V;
      4'h9: srcOf = amx_pkg::SRC_ANALOG_GROUND;
      default: srcOf = amx_pkg::SRC_SYSTEM_RAIL;
    endcase
  endfunction

  logic [3:0] sel;
  logic [1:0] pm;
  logic [1:0] en;
  logic [1:0] rng;
  logic [15:0] steps;
  assign sel = monCfg[amx_pkg::MON_SEL_MSB:amx_pkg::MON_SEL_LSB];
  assign pm = ldoModeCfg[amx_pkg::REGULATOR_POWER_MODE_MSB:amx_pkg::REGULATOR_POWER_MODE_LSB];
  assign en = ldoModeCfg[amx_pkg::REGULATOR_ENABLE_MODE_MSB:0];
  assign rng = sinkCfg[amx_pkg::SINK_RANGE_MSB:amx_pkg::SINK_RANGE_LSB];
  assign steps = {11'h000, sinkCfg[amx_pkg::SINK_BRT_MSB:0]} + 16'h0001;

  // --------------------
  // analog monitor
  // --------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      monitorChannelSelect <= amx_pkg::MON_SEL_OFF;
      monitorSource <= amx_pkg::SRC_OFF;
      monitorBufferOn <= 1'h0;
      chargeMonitorValid <= 1'h0;
      dischargeMonitorFullScale <= amx_pkg::MON_MUX_RST[7:4];
    end else if (ce) begin
      monitorChannelSelect <= sel;
      monitorSource <= srcOf(sel);
      monitorBufferOn <= (sel != amx_pkg::MON_SEL_OFF);
      chargeMonitorValid <= (sel == amx_pkg::MON_SEL_BAT_CHARGE_I) && chargingIndication;
      dischargeMonitorFullScale <= monCfg[amx_pkg::MON_SCALE_MSB:amx_pkg::MON_SCALE_LSB];
    end
  end

  // --------------------
  // regulator
  // --------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regulatorOn <= 1'h0;
      regulatorNormalMode <= 1'h0;
      regulatorActiveDischarge <= amx_pkg::LDO_ADE_RST;
      regulatorVoltageCode <= 7'h00;
      regulatorTargetMv <= amx_pkg::LDO_BASE_MV;
    end else if (ce) begin
      case (en)
        amx_pkg::EN_FORCED_OFF: regulatorOn <= 1'h0;
        amx_pkg::EN_FORCED_ON: regulatorOn <= 1'h1;
        default: regulatorOn <= !activeLowEnableIn_b || chargerInputValid;
      endcase
      case (pm)
        amx_pkg::PM_FORCED_LOW: regulatorNormalMode <= 1'h0;
        amx_pkg::PM_FORCED_NORMAL: regulatorNormalMode <= 1'h1;
        amx_pkg::PM_PIN_HIGH: regulatorNormalMode <= powerModePin;
        default: regulatorNormalMode <= !powerModePin;
      endcase
      regulatorActiveDischarge <= ldoVoltCfg[amx_pkg::LDO_ADE_BIT];
      regulatorVoltageCode <= ldoVoltCfg[amx_pkg::REGULATOR_VOLTAGE_CODE_MSB:0];
      regulatorTargetMv <= amx_pkg::LDO_BASE_MV + 12'(ldoVoltCfg[amx_pkg::REGULATOR_VOLTAGE_CODE_MSB:0] * amx_pkg::LDO_STEP_MV);
    end
  end

  // --------------------
  // sink one
  // --------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sinkOneEnabled <= 1'h0;
      sinkOneRange <= amx_pkg::SINK_RANGE_OFF;
      sinkOneCurrentUa <= 16'h0000;
      sinkOneOn <= 1'h0;
    end else if (ce) begin
      sinkOneEnabled <= (rng != amx_pkg::SINK_RANGE_OFF);
      sinkOneRange <= rng;
      if (rng == amx_pkg::SINK_RANGE_OFF) begin
        sinkOneCurrentUa <= 16'h0000;
      end else begin
        sinkOneCurrentUa <= 16'((steps * amx_pkg::SINK_LSB_UA) << (rng - 2'h1));
      end
      sinkOneOn <= (rng != amx_pkg::SINK_RANGE_OFF) && (blinkDutyActive ^ sinkCfg[amx_pkg::SINK_INV_BIT]);
    end
  end
endmodule
`default_nettype wire

// ---- design/amx_config_regs.sv ----
// monitor mux, regulator and sink one config bank behind an i2c target
// assumes pins synchronous to clk, scl at most a few percent of clk rate
//
// What this block does
// - four-bit channel select in bits 3:0; zero disables mux, output high impedance
// - codes one to three route charger voltage, charger current, battery voltage
// - code four routes charge current monitor, valid only while charging
// - codes five and six route discharge monitor, normal and nulling
// - codes seven to nine route thermistor, thermistor bias, ground
// - codes ten to fifteen all route the system rail
// - bits 7:4 choose discharge monitor full scale, 8.2 to 300mA
// - bit 7 of voltage register enables discharge resistor, default one
// - seven-bit voltage code, 0.8V plus 25mV per step
// - power mode zero forces low power, one forces normal
// - power mode two follows pin high, three follows pin low
// - enable code zero forces off, one forces on
// - enable codes two and three: on when enable input low or charger valid
// - sink range zero disables, others give 3.2, 6.4, 12.8mA scale
// - invert bit flips whether sink is on at start of period
// - brightness gives code plus one steps, ignored while disabled
`timescale 1ns/1ps
`default_nettype none
module amx_config_regs #(
  // target address value is arbitrary
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter logic [6:0] REGULATOR_VOLTAGE_CODE_OTP = 7'h00,
  parameter logic [1:0] REGULATOR_ENABLE_MODE_OTP = 2'h0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOutEn_b,
  input wire logic powerModePin,
  input wire logic activeLowEnableIn_b,
  input wire logic chargerInputValid,
  input wire logic chargingIndication,
  input wire logic blinkDutyActive,
  output logic [3:0] monitorChannelSelect,
  output amx_pkg::amx_src_t monitorSource,
  output logic monitorBufferOn,
  output logic chargeMonitorValid,
  output logic [3:0] dischargeMonitorFullScale,
  output logic regulatorOn,
  output logic regulatorNormalMode,
  output logic regulatorActiveDischarge,
  output logic [6:0] regulatorVoltageCode,
  output logic [11:0] regulatorTargetMv,
  output logic sinkOneEnabled,
  output logic [1:0] sinkOneRange,
  output logic [15:0] sinkOneCurrentUa,
  output logic sinkOneOn
);
  // --------------------
  // declarations
  // --------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } amx_i2c_state_t;

  amx_i2c_state_t state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] rxShift_ff;
  logic [7:0] txShift_ff;
  logic rdMode_ff;
  logic masterAck_ff;
  logic [7:0] regPtr_ff;
  logic wrEn_ff;
  logic [7:0] wrAddr_ff;
  logic [7:0] wrData_ff;
  logic [7:0] monCfg_ff;
  logic [7:0] ldoVoltCfg_ff;
  logic [3:0] ldoModeCfg_ff;
  logic [7:0] sinkCfg_ff;
  logic [7:0] rdByte;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // --------------------
  // read-back map
  // --------------------
  // unused bits zero
  function automatic logic [7:0] regRead(input logic [7:0] addr);
    case (addr)
      amx_pkg::REG_MON_MUX: regRead = monCfg_ff;
      amx_pkg::REG_LDO_VOLT: regRead = ldoVoltCfg_ff;
      amx_pkg::REG_LDO_MODE: regRead = {4'h0, ldoModeCfg_ff};
      amx_pkg::REG_SINK_ONE: regRead = sinkCfg_ff;
      default: regRead = 8'h00;
    endcase
  endfunction

  assign rdByte = regRead(regPtr_ff);

  // --------------------
  // pin edges
  // --------------------
  amx_i2c_line u_line (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .scl(scl),
    .sdaIn(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // --------------------
  // serial target
  // --------------------
  // data only moves after a detected scl fall, so it never changes while scl is high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      bitCnt_ff <= 4'h0;
      rxShift_ff <= 8'h00;
      txShift_ff <= 8'h00;
      rdMode_ff <= 1'h0;
      masterAck_ff <= 1'h0;
      regPtr_ff <= 8'h00;
      wrEn_ff <= 1'h0;
      wrAddr_ff <= 8'h00;
      wrData_ff <= 8'h00;
      sdaOut <= 1'h0;
      sdaOutEn_b <= 1'h1;
    end else if (ce) begin
      wrEn_ff <= 1'h0;
      sdaOut <= 1'h0;
      if (stopSeen) begin
        state_ff <= ST_IDLE;
        sdaOutEn_b <= 1'h1;
      end else if (startSeen) begin
        state_ff <= ST_ADDR;
        bitCnt_ff <= 4'h0;
        sdaOutEn_b <= 1'h1;
      end else begin
        case (state_ff)
          ST_ADDR: begin
            if (sclRise) begin
              rxShift_ff <= {rxShift_ff[6:0], sdaIn};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == amx_pkg::BYTE_BITS) begin
              bitCnt_ff <= 4'h0;
              if (rxShift_ff[7:1] == DEV_ADDR) begin
                rdMode_ff <= rxShift_ff[0];
                sdaOutEn_b <= 1'h0;
                state_ff <= ST_ADDR_ACK;
              end else begin
                state_ff <= ST_IGNORE;
              end
            end
          end
          ST_PTR: begin
            if (sclRise) begin
              rxShift_ff <= {rxShift_ff[6:0], sdaIn};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == amx_pkg::BYTE_BITS) begin
              bitCnt_ff <= 4'h0;
              regPtr_ff <= rxShift_ff;
              sdaOutEn_b <= 1'h0;
              state_ff <= ST_PTR_ACK;
            end
          end
          ST_WDATA: begin
            if (sclRise) begin
              rxShift_ff <= {rxShift_ff[6:0], sdaIn};
              bitCnt_ff <= bitCnt_ff + 4'h1;
            end else if (sclFall && bitCnt_ff == amx_pkg::BYTE_BITS) begin
              bitCnt_ff <= 4'h0;
              wrEn_ff <= 1'h1;
              wrAddr_ff <= regPtr_ff;
              wrData_ff <= rxShift_ff;
              regPtr_ff <= regPtr_ff + 8'h01;
              sdaOutEn_b <= 1'h0;
              state_ff <= ST_WDATA_ACK;
            end
          end
          ST_ADDR_ACK: begin
            if (sclFall) begin
              if (rdMode_ff) begin
                // enable low pulls the line to the zero bit value
                txShift_ff <= rdByte;
                sdaOutEn_b <= rdByte[7];
                regPtr_ff <= regPtr_ff + 8'h01;
                state_ff <= ST_RDATA;
              end else begin
                sdaOutEn_b <= 1'h1;
                state_ff <= ST_PTR;
              end
            end
          end
          ST_PTR_ACK, ST_WDATA_ACK: begin
            if (sclFall) begin
              sdaOutEn_b <= 1'h1;
              state_ff <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (sclFall) begin
              if (bitCnt_ff == amx_pkg::LAST_BIT) begin
                bitCnt_ff <= 4'h0;
                sdaOutEn_b <= 1'h1;
                state_ff <= ST_RACK;
              end else begin
                txShift_ff <= {txShift_ff[6:0], 1'h0};
                sdaOutEn_b <= txShift_ff[6];
                bitCnt_ff <= bitCnt_ff + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              masterAck_ff <= !sdaIn;
            end else if (sclFall) begin
              if (masterAck_ff) begin
                txShift_ff <= rdByte;
                sdaOutEn_b <= rdByte[7];
                regPtr_ff <= regPtr_ff + 8'h01;
                state_ff <= ST_RDATA;
              end else begin
                sdaOutEn_b <= 1'h1;
                state_ff <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE, ST_IDLE: begin
            sdaOutEn_b <= 1'h1;
          end
          default: begin
            sdaOutEn_b <= 1'h1;
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------
  // register bank
  // --------------------
  // system reset restores every field, otp fields come from parameters
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      monCfg_ff <= amx_pkg::MON_MUX_RST;
      ldoVoltCfg_ff <= {amx_pkg::LDO_ADE_RST, REGULATOR_VOLTAGE_CODE_OTP};
      ldoModeCfg_ff <= {amx_pkg::REGULATOR_POWER_MODE_RST, REGULATOR_ENABLE_MODE_OTP};
      sinkCfg_ff <= amx_pkg::SINK_ONE_RST;
    end else if (ce && wrEn_ff) begin
      case (wrAddr_ff)
        amx_pkg::REG_MON_MUX: monCfg_ff <= wrData_ff;
        amx_pkg::REG_LDO_VOLT: ldoVoltCfg_ff <= wrData_ff;
        amx_pkg::REG_LDO_MODE: ldoModeCfg_ff <= wrData_ff[3:0];
        amx_pkg::REG_SINK_ONE: sinkCfg_ff <= wrData_ff;
        default: monCfg_ff <= monCfg_ff;
      endcase
    end
  end

  // --------------------
  // control decode
  // --------------------
  amx_ctl_decode u_decode (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .monCfg(monCfg_ff),
    .ldoVoltCfg(ldoVoltCfg_ff),
    .ldoModeCfg(ldoModeCfg_ff),
    .sinkCfg(sinkCfg_ff),
    .powerModePin(powerModePin),
    .activeLowEnableIn_b(activeLowEnableIn_b),
    .chargerInputValid(chargerInputValid),
    .chargingIndication(chargingIndication),
    .blinkDutyActive(blinkDutyActive),
    .monitorChannelSelect(monitorChannelSelect),
    .monitorSource(monitorSource),
    .monitorBufferOn(monitorBufferOn),
    .chargeMonitorValid(chargeMonitorValid),
    .dischargeMonitorFullScale(dischargeMonitorFullScale),
    .regulatorOn(regulatorOn),
    .regulatorNormalMode(regulatorNormalMode),
    .regulatorActiveDischarge(regulatorActiveDischarge),
    .regulatorVoltageCode(regulatorVoltageCode),
    .regulatorTargetMv(regulatorTargetMv),
    .sinkOneEnabled(sinkOneEnabled),
    .sinkOneRange(sinkOneRange),
    .sinkOneCurrentUa(sinkOneCurrentUa),
    .sinkOneOn(sinkOneOn)
  );
endmodule
`default_nettype wire

// ---- tb/amx_host_model.sv ----
// i2c host model: single-byte register write and read on an open-drain bus
// assumes the bench resolves the wire level with a pull-up
`timescale 1ns/1ps
`default_nettype none
module amx_host_model #(
  // target address value is arbitrary
  parameter logic [6:0] ADDR = 7'h2A
) (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrv
);
  // ------------------------------
  // bus cycles
  // ------------------------------
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // six-cycle phases keep clear of the four-cycle minimum
  task automatic bitx(input logic d, output logic q);
    sdaDrv <= d;
    tick(3);
    scl <= 1'b1;
    tick(6);
    q = sdaLine;
    scl <= 1'b0;
    tick(3);
  endtask
  // also serves as repeated start
  task automatic start();
    sdaDrv <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(6);
    sdaDrv <= 1'b0;
    tick(6);
    scl <= 1'b0;
    tick(3);
  endtask
  // clock stays high after stop, the bus stands still between frames
  task automatic stop();
    sdaDrv <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(6);
    sdaDrv <= 1'b1;
    tick(6);
  endtask
  task automatic xfer(input logic [7:0] b, input logic mAck, output logic [7:0] r,
      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
    bitx(mAck, ack);
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
  // one byte then nack, which ends the read
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start();
    xfer({ADDR, 1'b0}, 1'b1, r, a0);
    xfer(p, 1'b1, r, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, r, a2);
    xfer(8'hFF, 1'b1, d, a3);
    stop();
    ok = !(a0 | a1 | a2);
  endtask
endmodule
`default_nettype wire

// ---- tb/amx_config_regs_sva.sv ----
// checker on the decode outputs of the config bank
// assumes it is bound to amx_config_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module amx_config_regs_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chargingIndication,
  input wire logic sdaOutEn_b,
  input wire logic [3:0] monitorChannelSelect,
  input wire amx_pkg::amx_src_t monitorSource,
  input wire logic monitorBufferOn,
  input wire logic chargeMonitorValid,
  input wire logic regulatorOn,
  input wire logic [6:0] regulatorVoltageCode,
  input wire logic [11:0] regulatorTargetMv,
  input wire logic sinkOneEnabled,
  input wire logic [1:0] sinkOneRange,
  input wire logic [15:0] sinkOneCurrentUa,
  input wire logic sinkOneOn
);
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_buffer_sel_match: assert property (monitorBufferOn == (monitorChannelSelect != 4'h0))
    else $error("monitor buffer state disagrees with select");
  a_source_off_zero: assert property (monitorChannelSelect == 4'h0 |->
    monitorSource == amx_pkg::SRC_OFF) else $error("select zero not off");
  a_low_codes_direct: assert property (monitorChannelSelect inside {[4'h1:4'h9]} |->
    monitorSource == amx_pkg::amx_src_t'(monitorChannelSelect)) else $error("bad source");
  a_high_codes_rail: assert property (monitorChannelSelect > 4'h9 |->
    monitorSource == amx_pkg::SRC_SYSTEM_RAIL) else $error("high code not rail");
  a_charge_valid_gate: assert property (chargeMonitorValid ==
    (monitorChannelSelect == 4'h4 && $past(chargingIndication))) else $error("charge valid");
  a_target_linear: assert property (
    regulatorTargetMv == 12'h320 + 12'h019 * regulatorVoltageCode) else $error("target mv");
  a_sink_range_enable: assert property (sinkOneEnabled == (sinkOneRange != 2'h0))
    else $error("sink enable");
  a_sink_off_zero: assert property (!sinkOneEnabled |->
    sinkOneCurrentUa == 16'h0000 && !sinkOneOn) else $error("disabled sink active");
  a_sink_step_max: assert property (sinkOneEnabled |-> sinkOneCurrentUa != 16'h0000 &&
    sinkOneCurrentUa % (16'h0064 << (sinkOneRange - 2'h1)) == 16'h0000 &&
    sinkOneCurrentUa <= (16'h0C80 << (sinkOneRange - 2'h1))) else $error("sink step");
  cover property (chargeMonitorValid);
  cover property (sinkOneOn);
  cover property (regulatorOn && monitorSource == amx_pkg::SRC_SYSTEM_RAIL);
  cover property (!sdaOutEn_b);
endmodule
bind amx_config_regs amx_config_regs_sva amx_config_regs_sva_i (.clk(clk), .rst_b(rst_b),
  .chargingIndication(chargingIndication), .sdaOutEn_b(sdaOutEn_b),
  .monitorChannelSelect(monitorChannelSelect), .monitorSource(monitorSource),
  .monitorBufferOn(monitorBufferOn), .chargeMonitorValid(chargeMonitorValid),
  .regulatorOn(regulatorOn), .regulatorVoltageCode(regulatorVoltageCode),
  .regulatorTargetMv(regulatorTargetMv), .sinkOneEnabled(sinkOneEnabled),
  .sinkOneRange(sinkOneRange), .sinkOneCurrentUa(sinkOneCurrentUa), .sinkOneOn(sinkOneOn));
`default_nettype wire

// ---- tb/testbench.sv ----
// bench for the config bank: random register traffic against a register model
// assumes the host model drives the bus; ce held high throughout
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_b, pmPin, enIn_b, chgValid, chgInd, blink, scl, sdaDrv, sdaOut, sdaOutEn_b;
  logic ok, monitorBufferOn, chargeMonitorValid, regulatorOn, regulatorNormalMode;
  logic regulatorActiveDischarge, sinkOneEnabled, sinkOneOn;
  logic [3:0] monitorChannelSelect, dischargeMonitorFullScale;
  amx_pkg::amx_src_t monitorSource;
  logic [6:0] regulatorVoltageCode;
  logic [11:0] regulatorTargetMv;
  logic [1:0] sinkOneRange;
  logic [15:0] sinkOneCurrentUa;
  logic [7:0] m [4];
  logic [7:0] rd;
  logic [31:0] seed = 32'hBF75CE35;
  logic [31:0] v;
  int errors = 0;
  int n_tests = 0;
  wire logic sdaLine;
  localparam logic [7:0] ADR [4] = '{amx_pkg::REG_MON_MUX, amx_pkg::REG_LDO_VOLT,
    amx_pkg::REG_LDO_MODE, amx_pkg::REG_SINK_ONE};
  // open drain with pull-up
  assign sdaLine = sdaDrv & (sdaOutEn_b | sdaOut);
  amx_config_regs amx_config_regs_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .scl(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOutEn_b(sdaOutEn_b), .powerModePin(pmPin),
    .activeLowEnableIn_b(enIn_b), .chargerInputValid(chgValid), .chargingIndication(chgInd),
    .blinkDutyActive(blink), .monitorChannelSelect(monitorChannelSelect),
    .monitorSource(monitorSource), .monitorBufferOn(monitorBufferOn),
    .chargeMonitorValid(chargeMonitorValid),
    .dischargeMonitorFullScale(dischargeMonitorFullScale), .regulatorOn(regulatorOn),
    .regulatorNormalMode(regulatorNormalMode), .regulatorActiveDischarge(regulatorActiveDischarge),
    .regulatorVoltageCode(regulatorVoltageCode), .regulatorTargetMv(regulatorTargetMv),
    .sinkOneEnabled(sinkOneEnabled), .sinkOneRange(sinkOneRange),
    .sinkOneCurrentUa(sinkOneCurrentUa), .sinkOneOn(sinkOneOn));
  amx_host_model amx_host_model_i (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    amx_host_model_i.write_reg(ADR[k], d, ok);
    chk(16'(ok), 16'h0001);
    m[k] = (k == 2) ? {4'h0, d[3:0]} : d;
  endtask
  task automatic check_reg(input int k);
    amx_host_model_i.read_reg(ADR[k], rd, ok);
    chk(16'(ok), 16'h0001);
    chk(16'(rd), 16'(m[k]));
  endtask
  task automatic check_outs();
    logic [3:0] s;
    logic [1:0] pm, en, rg;
    s = m[0][3:0];
    pm = m[2][3:2];
    en = m[2][1:0];
    rg = m[3][7:6];
    chk(16'(monitorChannelSelect), 16'(s));
    chk(16'(monitorSource), 16'((s > 9) ? 10 : s));
    chk(16'(monitorBufferOn), 16'(s != 0));
    chk(16'(chargeMonitorValid), 16'(s == 4 && chgInd));
    chk(16'(dischargeMonitorFullScale), 16'(m[0][7:4]));
    chk(16'(regulatorActiveDischarge), 16'(m[1][7]));
    chk(16'(regulatorVoltageCode), 16'(m[1][6:0]));
    chk(16'(regulatorTargetMv), 16'(800 + 25 * m[1][6:0]));
    chk(16'(regulatorNormalMode), 16'(pm[1] ? (pm[0] ^ pmPin) : pm[0]));
    chk(16'(regulatorOn), 16'(en[1] ? (!enIn_b || chgValid) : en[0]));
    chk(16'(sinkOneRange), 16'(rg));
    chk(16'(sinkOneEnabled), 16'(rg != 0));
    chk(sinkOneCurrentUa, 16'(rg == 0 ? 0 : ((m[3][4:0] + 1) * 100) << (rg - 1)));
    chk(16'(sinkOneOn), 16'(rg != 0 && (blink ^ m[3][5])));
  endtask
  task automatic close_out();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------
  // run
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang is cut short well beyond the expected run length
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: run timed out", $time);
    close_out();
  end
  initial begin
    {rst_b, pmPin, enIn_b, chgValid, chgInd, blink} = 6'b001000;
    m = '{8'hF0, 8'h80, 8'h04, 8'h04};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 4; k++) check_reg(k);
    check_outs();
    // even passes walk every select and mode code, odd passes are random
    for (int i = 0; i < 64; i++) begin
      v = rnd();
      {pmPin, enIn_b, chgValid, chgInd, blink} <= v[12:8];
      wr(i % 4, i[0] ? v[7:0] : {v[7:4], i[5:2]});
      if (i % 8 == 7) begin
        amx_host_model_i.write_reg(8'h29, v[7:0], ok);
        amx_host_model_i.read_reg(8'h29, rd, ok);
        chk(16'(rd), 16'h0000);
      end
      check_reg(i % 4);
      check_outs();
    end
    // idle select saves the buffer current
    wr(0, m[0] & 8'hF0);
    check_outs();
    close_out();
  end
endmodule
`default_nettype wire
